// file: hdl/machine_check_io_int.sv
// machine-check interruption and i/o interrupt code sequencer of a computing element
`timescale 1ns/100ps

// How it works
// - internal check terminates current instruction
// - internal check pulses element check outward
// - log state out from location 80h
// - store old word at 30h, code zero
// - fetch new status word from 70h
// - read-direct timeout raises machine check
// - timeout check: no terminate, no logout
// - timeout check carries interrupt code four
// - busy too long during read-direct: timeout
// - status bit 13 masks machine checks
// - masked: finish instruction, go sequential
// - bit 13 masks i/o element check requests
// - complete non-i/o instruction before acknowledging
// - i/o instruction terminated on i/o request
// - i/o interrupt: old 38h, new 78h
// - i/o code: channel nibble plus device address
module machine_check_io_int
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // error sources and status word
  input  wire logic             internalErr,
  input  wire logic             curPswMck,
  input  wire logic             instrDone,
  input  wire logic             ioInstr,
  // read-direct port (pins)
  input  wire logic             readDirectActive,
  input  wire logic             directInBusy,
  // request from the i/o computing element (pin)
  input  wire logic             ioMckReq,
  // i/o interrupt request from channels
  input  wire logic             ioIntReq,
  input  wire logic [3:0]       ioChannel,
  input  wire logic [7:0]       ioDevAddr,
  // storage handshake
  input  wire logic             psaAck,
  // instruction control
  output logic                  terminateInstr,
  output logic                  elementCheckPulse,
  output logic                  ioMckAck,
  output logic                  ioIntAck,
  output logic                  swapDone,
  // storage requests
  output mck_pkg::psa_req_s     psaReq
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] busySync_ff;
  logic [1:0] ioReqSync_ff;
  logic       busyS;
  logic       ioReqS;

  // two flops before any logic sees the busy and i/o request pins; readDirectActive is used unsynchronised
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      busySync_ff  <= 2'h0;
      ioReqSync_ff <= 2'h0;
    end
    else
    begin
      busySync_ff  <= {busySync_ff[0], directInBusy};
      ioReqSync_ff <= {ioReqSync_ff[0], ioMckReq};
    end
  end

  assign busyS  = busySync_ff[1];
  assign ioReqS = ioReqSync_ff[1];

  // ==========================================================
  // read-direct timeout
  logic [15:0] busyCnt_ff;
  logic        rdTmo;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      busyCnt_ff <= 16'h0000;
    end
    else if (readDirectActive && busyS && busyCnt_ff != mck_pkg::RD_TMO_CYC)
    begin
      busyCnt_ff <= busyCnt_ff + 16'h0001;
    end
    else if (!(readDirectActive && busyS))
    begin
      busyCnt_ff <= 16'h0000;
    end
  end

  // timeout fires once at the limit
  assign rdTmo = readDirectActive && busyS
                 && (busyCnt_ff == mck_pkg::RD_TMO_CYC - 16'h0001);

  // ==========================================================
  // pending causes (set wins over clear)
  logic intPend_ff;
  logic tmoPend_ff;
  logic ioPend_ff;
  logic ioReqD_ff;
  logic takeInt;
  logic takeTmo;
  logic takeIo;
  logic takeIoInt;

  mck_pkg::act_state_e state_ff;
  logic                idle;

  assign idle = (state_ff == mck_pkg::ST_IDLE);

  // status bit gates every machine check
  assign takeInt = idle && intPend_ff && curPswMck;
  assign takeTmo = idle && !intPend_ff && tmoPend_ff && curPswMck;
  // i/o request waits for mask, and for completion unless ioInstr
  assign takeIo  = idle && !intPend_ff && !tmoPend_ff && ioPend_ff && curPswMck
                   && (instrDone || ioInstr);
  assign takeIoInt = idle && !intPend_ff && !tmoPend_ff && !(ioPend_ff && curPswMck)
                     && ioIntReq && instrDone;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      intPend_ff <= 1'b0;
    end
    else
    begin
      intPend_ff <= internalErr || (intPend_ff && !takeInt);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tmoPend_ff <= 1'b0;
    end
    else
    begin
      tmoPend_ff <= rdTmo || (tmoPend_ff && !takeTmo);
    end
  end

  // i/o element request: latch the synced rising edge
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ioReqD_ff <= 1'b0;
      ioPend_ff <= 1'b0;
    end
    else
    begin
      ioReqD_ff <= ioReqS;
      ioPend_ff <= (ioReqS && !ioReqD_ff) || (ioPend_ff && !takeIo);
    end
  end

  // ==========================================================
  // element check pulse and instruction termination
  // one pulse on every internal error, unmasked
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      elementCheckPulse <= 1'b0;
    end
    else
    begin
      elementCheckPulse <= internalErr;
    end
  end

  // terminate internal or i/o instruction only
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      terminateInstr <= 1'b0;
    end
    else
    begin
      terminateInstr <= takeInt || (takeIo && ioInstr);
    end
  end

  // acknowledge pulse for a taken i/o element check
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ioMckAck <= 1'b0;
    end
    else
    begin
      ioMckAck <= takeIo;
    end
  end

  // acknowledge pulse for a taken i/o interruption
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ioIntAck <= 1'b0;
    end
    else
    begin
      ioIntAck <= takeIoInt;
    end
  end

  // ==========================================================
  // storage sequencer
  logic [7:0]  logCnt_ff;
  logic [15:0] code_ff;
  logic [11:0] oldLoc_ff;
  logic [11:0] newLoc_ff;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_ff  <= mck_pkg::ST_IDLE;
      logCnt_ff <= 8'h00;
      code_ff   <= 16'h0000;
      oldLoc_ff <= 12'h000;
      newLoc_ff <= 12'h000;
    end
    else
    begin
      case (state_ff)
        mck_pkg::ST_IDLE:
        begin
          logCnt_ff <= 8'h00;
          oldLoc_ff <= mck_pkg::MCK_OLD_PSW;
          newLoc_ff <= mck_pkg::MCK_NEW_PSW;
          if (takeInt)
          begin
            code_ff  <= mck_pkg::CODE_INTERNAL;
            state_ff <= mck_pkg::ST_LOGOUT;
          end
          else if (takeTmo)
          begin
            code_ff  <= mck_pkg::CODE_RD_TMO;
            state_ff <= mck_pkg::ST_OLD;
          end
          else if (takeIo)
          begin
            code_ff  <= mck_pkg::CODE_INTERNAL;
            state_ff <= mck_pkg::ST_OLD;
          end
          else if (takeIoInt)
          begin
            code_ff   <= {4'h0, (ioChannel > mck_pkg::CHAN_MAX) ? 4'h0 : ioChannel,
                          ioDevAddr};
            oldLoc_ff <= mck_pkg::IO_OLD_PSW;
            newLoc_ff <= mck_pkg::IO_NEW_PSW;
            state_ff  <= mck_pkg::ST_OLD;
          end
        end
        mck_pkg::ST_LOGOUT:
          if (psaAck)
          begin
            logCnt_ff <= logCnt_ff + 8'h01;
            if (logCnt_ff == mck_pkg::LOGOUT_WORDS - 8'h01)
              state_ff <= mck_pkg::ST_OLD;
          end
        mck_pkg::ST_OLD:
        begin
          if (psaAck)
          begin
            state_ff <= mck_pkg::ST_NEW;
          end
        end
        mck_pkg::ST_NEW:
        begin
          if (psaAck)
          begin
            state_ff <= mck_pkg::ST_DONE;
          end
        end
        mck_pkg::ST_DONE:
        begin
          state_ff <= mck_pkg::ST_IDLE;
        end
        default:
        begin
          state_ff <= mck_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // storage request drive
  always_comb
  begin
    psaReq       = '0;
    psaReq.code  = code_ff;
    case (state_ff)
      mck_pkg::ST_LOGOUT:
      begin
        psaReq.valid = 1'b1;
        psaReq.write = 1'b1;
        psaReq.addr  = mck_pkg::LOGOUT_START + {2'h0, logCnt_ff, 2'h0};
      end
      mck_pkg::ST_OLD:
      begin
        psaReq.valid = 1'b1;
        psaReq.write = 1'b1;
        psaReq.addr  = oldLoc_ff;
      end
      mck_pkg::ST_NEW:
      begin
        psaReq.valid = 1'b1;
        psaReq.addr  = newLoc_ff;
      end
      default:
      begin
        psaReq.addr = 12'h000;
      end
    endcase
  end

  assign swapDone = (state_ff == mck_pkg::ST_DONE);

endmodule

// file: hdl/mck_pkg.sv
// shared constants and carrier types for the machine-check and i/o interrupt unit
package mck_pkg;

  // ==========================================================
  // storage locations in the prefixed storage area (byte offsets)
  localparam logic [11:0] LOGOUT_START   = 12'h080;
  localparam logic [11:0] MCK_OLD_PSW    = 12'h030;
  localparam logic [11:0] MCK_NEW_PSW    = 12'h070;
  localparam logic [11:0] IO_OLD_PSW     = 12'h038;
  localparam logic [11:0] IO_NEW_PSW     = 12'h078;

  // ==========================================================
  // status word fields and interrupt codes
  localparam int          MCK_MASK_BIT   = 13;
  localparam logic [15:0] CODE_INTERNAL  = 16'h0000;
  localparam logic [15:0] CODE_RD_TMO    = 16'h0004;
  localparam logic [3:0]  CHAN_MAX       = 4'hA;
  localparam logic [7:0]  LOGOUT_WORDS   = 8'h10;

  // ==========================================================
  // read-direct busy timeout
  localparam int          RD_TMO_NS      = 1000;
  localparam int          CLK_NS         = 4;
  localparam logic [15:0] RD_TMO_CYC     = 16'(RD_TMO_NS / CLK_NS);

  // ==========================================================
  // action sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_LOGOUT = 3'b001,
    ST_OLD    = 3'b010,
    ST_NEW    = 3'b011,
    ST_DONE   = 3'b100
  } act_state_e;

  // storage write/read request toward the prefixed storage area
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [15:0] code;
  } psa_req_s;

endpackage

// file: tb/mck_props.sv
// port assertions for the machine-check sequencer
`timescale 1ns/100ps
module mck_props
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // causes and status
  input wire logic              internalErr,
  input wire logic              curPswMck,
  input wire logic              instrDone,
  input wire logic              ioInstr,
  input wire logic              psaAck,
  // results
  input wire logic              terminateInstr,
  input wire logic              elementCheckPulse,
  input wire logic              ioMckAck,
  input wire logic              swapDone,
  input wire mck_pkg::psa_req_s psaReq
);
  // ====
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_PULSE: assert property (internalErr |=> elementCheckPulse)
    else $error("check pulse missing");
  AST_PULSE_CAUSE: assert property (elementCheckPulse |-> $past(internalErr))
    else $error("check pulse without cause");
  AST_TERM_MASK: assert property (terminateInstr |-> $past(curPswMck))
    else $error("terminate while masked");
  AST_IO_ACK: assert property (ioMckAck |-> $past(curPswMck) && ($past(instrDone) || $past(ioInstr)))
    else $error("i/o check taken early");
  AST_HOLD: assert property (psaReq.valid && !psaAck |=> $stable(psaReq))
    else $error("storage request changed");
  AST_LOG_WR: assert property (psaReq.valid && psaReq.addr >= 12'h080 |-> psaReq.write)
    else $error("logout not a write");
  AST_OLD_CODE: assert property (psaReq.valid && psaReq.addr == 12'h030 |-> psaReq.write && (psaReq.code == 16'h0000 || psaReq.code == 16'h0004))
    else $error("bad check old word");
  AST_NEW_RD: assert property (psaReq.valid && psaReq.addr[11:4] == 8'h07 |-> !psaReq.write)
    else $error("new word not a read");
  AST_IO_CODE: assert property (psaReq.valid && psaReq.addr == 12'h038 |-> psaReq.write && psaReq.code[15:12] == 4'h0 && psaReq.code[11:8] <= 4'hA)
    else $error("bad i/o code");
  // main scenarios reached
  cover property (swapDone);
  cover property (ioMckAck);
  cover property (psaReq.valid && psaReq.addr == 12'h038);
endmodule

// file: tb/io_element_model.sv
// far side: storage port, i/o element and direct-in line
`timescale 1ns/100ps
module io_element_model
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // storage side
  input wire mck_pkg::psa_req_s psaReq,
  output logic                  psaAck,
  // element pins
  output logic                  ioMckReq = 1'b0,
  output logic                  directInBusy = 1'b0
);
  mck_pkg::psa_req_s seen[$];
  // storage accepts every other cycle and logs each transfer
  always @(posedge core_clk)
  begin
    psaAck <= resetn && psaReq.valid && !psaAck;
    if (resetn && psaReq.valid && psaAck)
      seen.push_back(psaReq);
  end
  // after its own pulse and diagnosis
  task automatic raiseCheck();
    @(posedge core_clk) ioMckReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    ioMckReq <= 1'b0;
  endtask
  task automatic holdBusy(input int n);
    @(posedge core_clk) directInBusy <= 1'b1;
    repeat (n) @(posedge core_clk);
    directInBusy <= 1'b0;
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the machine-check sequencer
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0, resetn = 1'b0, internalErr = 1'b0, curPswMck = 1'b1;
  logic instrDone = 1'b0, ioInstr = 1'b0, readDirectActive = 1'b0, ioIntReq = 1'b0;
  logic [3:0] ioChannel = 4'h0;
  logic [7:0] ioDevAddr = 8'h00;
  logic directInBusy, ioMckReq, psaAck, terminateInstr, elementCheckPulse;
  logic ioMckAck, ioIntAck, swapDone;
  mck_pkg::psa_req_s psaReq;
  int mismatches = 0, comparisons = 0, elcs, terms, acks, swaps;
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  machine_check_io_int machine_check_io_int_inst (.core_clk(core_clk), .resetn(resetn),
    .internalErr(internalErr), .curPswMck(curPswMck), .instrDone(instrDone),
    .ioInstr(ioInstr), .readDirectActive(readDirectActive), .directInBusy(directInBusy),
    .ioMckReq(ioMckReq), .ioIntReq(ioIntReq), .ioChannel(ioChannel), .ioDevAddr(ioDevAddr),
    .psaAck(psaAck), .terminateInstr(terminateInstr), .elementCheckPulse(elementCheckPulse),
    .ioMckAck(ioMckAck), .ioIntAck(ioIntAck), .swapDone(swapDone), .psaReq(psaReq));
  io_element_model io_element_model_inst (.core_clk(core_clk), .resetn(resetn),
    .psaReq(psaReq), .psaAck(psaAck), .ioMckReq(ioMckReq), .directInBusy(directInBusy));
  // pulse counters
  always @(posedge core_clk)
  begin
    elcs <= !resetn ? 0 : elcs + int'(elementCheckPulse);
    terms <= !resetn ? 0 : terms + int'(terminateInstr);
    acks <= !resetn ? 0 : acks + int'(ioMckAck);
    swaps <= !resetn ? 0 : swaps + int'(swapDone);
  end
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  // compare one logged transfer, code only on writes
  task automatic checkReq(input int i, input logic w, input logic [11:0] a,
                          input logic [15:0] c);
    mck_pkg::psa_req_s q;
    q = io_element_model_inst.seen[i];
    check(32'({q.valid, q.write, q.addr, w ? q.code : c}), 32'({1'b1, w, a, c}));
  endtask
  task automatic waitSwap(input int bound);
    int s;
    s = swaps;
    repeat (bound)
    begin
      @(posedge core_clk);
      if (swaps != s)
        return;
    end
    mismatches++;
    test_done();
  endtask
  // masked internal check, then unmasked service
  task automatic scnInternal();
    io_element_model_inst.seen.delete();
    curPswMck <= 1'b0;
    internalErr <= 1'b1;
    @(posedge core_clk) internalErr <= 1'b0;
    repeat (20) @(posedge core_clk);
    check(elcs, 1);
    check(terms + io_element_model_inst.seen.size(), 0);
    curPswMck <= 1'b1;
    waitSwap(200);
    check(terms, 1);
    for (int i = 0; i < 16; i++)
      checkReq(i, 1'b1, 12'h080 + 12'(4 * i), 16'h0000);
    checkReq(16, 1'b1, 12'h030, 16'h0000);
    checkReq(17, 1'b0, 12'h070, 16'h0000);
  endtask
  // short busy passes, long busy times out
  task automatic scnTimeout();
    io_element_model_inst.seen.delete();
    readDirectActive <= 1'b1;
    io_element_model_inst.holdBusy(100);
    repeat (200) @(posedge core_clk);
    check(swaps, 1);
    io_element_model_inst.holdBusy(270);
    repeat (20) @(posedge core_clk);
    readDirectActive <= 1'b0;
    check(swaps, 2);
    check(terms + io_element_model_inst.seen.size(), 3);
    checkReq(0, 1'b1, 12'h030, 16'h0004);
    checkReq(1, 1'b0, 12'h070, 16'h0000);
  endtask
  // i/o element check: masked, waits, then ends an i/o instruction
  task automatic scnIoCheck();
    curPswMck <= 1'b0;
    io_element_model_inst.raiseCheck();
    repeat (20) @(posedge core_clk);
    check(acks, 0);
    curPswMck <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(acks, 0);
    ioInstr <= 1'b1;
    waitSwap(100);
    ioInstr <= 1'b0;
    check(acks + terms, 3);
    io_element_model_inst.raiseCheck();
    repeat (10) @(posedge core_clk);
    instrDone <= 1'b1;
    waitSwap(100);
    instrDone <= 1'b0;
    check(terms * 16 + acks, 34);
  endtask
  // every channel code, one beyond the last
  task automatic scnIoInt();
    instrDone <= 1'b1;
    for (int ch = 0; ch < 12; ch++)
    begin
      io_element_model_inst.seen.delete();
      ioChannel <= 4'(ch);
      ioDevAddr <= 8'(8'hA5 ^ ch);
      ioIntReq <= 1'b1;
      for (int n = 0; n < 20 && !ioIntAck; n++)
        @(negedge core_clk);
      check(32'(ioIntAck), 32'h1);
      @(posedge core_clk) ioIntReq <= 1'b0;
      waitSwap(100);
      checkReq(0, 1'b1, 12'h038, {4'h0, ch > 10 ? 4'h0 : 4'(ch), 8'(8'hA5 ^ ch)});
      checkReq(1, 1'b0, 12'h078, 16'h0000);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    scnInternal();
    scnTimeout();
    scnIoCheck();
    scnIoInt();
    test_done();
  end
endmodule
bind machine_check_io_int mck_props mck_props_inst (.core_clk(core_clk), .resetn(resetn),
  .internalErr(internalErr), .curPswMck(curPswMck), .instrDone(instrDone),
  .ioInstr(ioInstr), .psaAck(psaAck), .terminateInstr(terminateInstr),
  .elementCheckPulse(elementCheckPulse), .ioMckAck(ioMckAck), .swapDone(swapDone),
  .psaReq(psaReq));
